// >>> rtl/copro_port_pkg.sv
`default_nettype none
package copro_port_pkg;
  // ----------------------------------------
  // Port addresses in I/O space
  // ----------------------------------------
  localparam logic [31:0] OPCODE_PORT_ADDR = 32'h800000F8;
  localparam logic [31:0] OPERAND_PORT_ADDR = 32'h800000FC;
  // Top of the programmed-I/O range
  localparam logic [31:0] PIO_LIMIT = 32'h0000FFFF;
  // Address bit that picks opcode or operand port
  localparam int unsigned SELECT_BIT = 2;
  // Edges after reset until the pin synchronisers hold real pin levels
  localparam logic [2:0] SYNC_FILL = 3'h4;
  // ----------------------------------------
  // Opcodes and vectors
  // ----------------------------------------
  localparam logic [7:0] WAIT_OPCODE = 8'h9B;
  localparam logic [7:0] FAULT_VECTOR = 8'h10;
  // Bus cycle types
  localparam logic [1:0] CYC_NONE = 2'h0;
  localparam logic [1:0] CYC_OPCODE = 2'h1;
  localparam logic [1:0] CYC_OPERAND = 2'h2;
endpackage : copro_port_pkg
`default_nettype wire

// >>> rtl/numeric_coprocessor_port.sv
// Behaviour
// - Sample busy and error before command, no preamble
// - Wait opcode stalls while busy asserted
// - Enabled interrupts end the wait stall
// - Error at busy negation raises fault 16
// - Auto cycles: opcode F8h port, operand FCh port
// - Ports lie above programmed-I/O range
// - Sample error once after reset, picks protocol
`default_nettype none
module numeric_coprocessor_port (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  // Coprocessor status pins, active low busy/error
  input wire logic i_busy_n,
  input wire logic i_error_n,
  input wire logic i_operand_transfer_request,
  // Execution unit side
  input wire logic i_esc_start,
  input wire logic [31:0] i_esc_opcode,
  input wire logic i_wait_start,
  input wire logic i_nmi,
  input wire logic i_maskable_irq,
  input wire logic i_irq_enable,
  input wire logic [31:0] i_operand_data,
  // Bus unit handshake
  input wire logic i_bus_ready,
  // Bus cycle request
  output logic o_io_req,
  output logic [31:0] o_io_addr,
  output logic [31:0] o_io_wdata,
  output logic [1:0] o_io_kind,
  // Execution status
  output logic o_stall,
  output logic o_done,
  output logic o_fault,
  output logic [7:0] o_fault_vector,
  output logic o_irq_break,
  output logic o_proto32
);
  import copro_port_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Three stages per pin; stage 1 only feeds stage 2
  logic [2:0] busy_s1_reg, busy_s1_next;
  logic [2:0] busy_s2_reg, busy_s2_next;
  logic [2:0] busy_s3_reg, busy_s3_next;
  logic [2:0] flt_reg, flt_next;
  logic [2:0] pins;

  assign pins = {i_operand_transfer_request, ~i_error_n, ~i_busy_n};

  // Next values of the synchroniser chain
  always_comb begin
    busy_s1_next = pins;
    busy_s2_next = busy_s1_reg;
    busy_s3_next = busy_s2_reg;
    flt_next = flt_reg;
    // Accept change when stages 2 and 3 agree
    for (int k = 0; k < 3; k++) begin
      if (busy_s2_reg[k] == busy_s3_reg[k]) begin
        flt_next[k] = busy_s2_reg[k];
      end
    end
  end

  // Synchroniser registers
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      busy_s1_reg <= 3'h0;
      busy_s2_reg <= 3'h0;
      busy_s3_reg <= 3'h0;
      flt_reg <= 3'h0;
    end else begin
      busy_s1_reg <= busy_s1_next;
      busy_s2_reg <= busy_s2_next;
      busy_s3_reg <= busy_s3_next;
      flt_reg <= flt_next;
    end
  end

  logic busy;   // Busy asserted
  logic error;  // Error asserted
  logic preq;   // Operand request
  assign busy = flt_reg[0];
  assign error = flt_reg[1];
  assign preq = flt_reg[2];

  // ----------------------------------------
  // Control state machine
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_INIT, ST_IDLE, ST_CMD_WAIT, ST_CMD_BUS, ST_WAIT_OP, ST_OPND_BUS
  } state_e;

  state_e state_reg, state_next;
  logic proto_reg, proto_next;        // 32-bit protocol chosen
  logic sampled_reg, sampled_next;    // Strap sample taken
  logic [2:0] fill_reg, fill_next;    // Synchroniser fill count
  logic [7:0] fvec_reg, fvec_next;    // Registered fault vector
  logic req_reg, req_next;
  logic [31:0] addr_reg, addr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [1:0] kind_reg, kind_next;
  logic [31:0] opc_reg, opc_next;     // Pending command opcode
  logic stall_reg, stall_next;
  logic done_reg, done_next;
  logic fault_reg, fault_next;
  logic brk_reg, brk_next;
  logic irq_take;

  assign irq_take = i_nmi | (i_maskable_irq & i_irq_enable);

  // Next-state logic
  always_comb begin
    state_next = state_reg;
    proto_next = proto_reg;
    sampled_next = sampled_reg;
    fill_next = fill_reg;
    req_next = 1'b0;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    kind_next = CYC_NONE;
    opc_next = opc_reg;
    stall_next = 1'b0;
    done_next = 1'b0;
    fault_next = 1'b0;
    brk_next = 1'b0;
    case (state_reg)
      // Post-reset protocol sampling
      ST_INIT: begin
        if (fill_reg != SYNC_FILL) begin
          // Reset values of the chain are not pin levels yet
          fill_next = 3'(fill_reg + 3'h1);
        end else if (!sampled_reg && !busy) begin
          proto_next = error;
          sampled_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      // Waiting for work
      ST_IDLE: begin
        if (i_wait_start) begin
          stall_next = 1'b1;
          state_next = ST_WAIT_OP;
        end else if (i_esc_start) begin
          opc_next = i_esc_opcode;
          stall_next = 1'b1;
          state_next = ST_CMD_WAIT;
        end else if (preq) begin
          req_next = 1'b1;
          addr_next = OPERAND_PORT_ADDR;
          wdata_next = i_operand_data;
          kind_next = CYC_OPERAND;
          state_next = ST_OPND_BUS;
        end
      end
      // Coprocessor readiness check
      ST_CMD_WAIT: begin
        stall_next = 1'b1;
        if (!busy && !error) begin
          req_next = 1'b1;
          addr_next = OPCODE_PORT_ADDR;
          wdata_next = opc_reg;
          kind_next = CYC_OPCODE;
          state_next = ST_CMD_BUS;
        end else if (!busy && error) begin
          fault_next = 1'b1;
          stall_next = 1'b0;
          state_next = ST_IDLE;
        end
      end
      // Command cycle on the bus
      ST_CMD_BUS: begin
        stall_next = 1'b1;
        req_next = 1'b1;
        kind_next = kind_reg;
        if (i_bus_ready) begin
          req_next = 1'b0;
          kind_next = CYC_NONE;
          stall_next = 1'b0;
          done_next = 1'b1;
          state_next = ST_IDLE;
        end
      end
      // Wait opcode stall
      ST_WAIT_OP: begin
        stall_next = 1'b1;
        if (irq_take) begin
          stall_next = 1'b0;
          brk_next = 1'b1;
          state_next = ST_IDLE;
        end else if (!busy) begin
          stall_next = 1'b0;
          state_next = ST_IDLE;
          if (error) begin
            fault_next = 1'b1;
          end else begin
            done_next = 1'b1;
          end
        end
      end
      // Operand transfer cycles
      ST_OPND_BUS: begin
        req_next = 1'b1;
        kind_next = kind_reg;
        if (i_bus_ready) begin
          wdata_next = i_operand_data;
          if (!preq) begin
            req_next = 1'b0;
            kind_next = CYC_NONE;
            state_next = ST_IDLE;
          end
        end
      end
      default: begin
        state_next = ST_INIT;
      end
    endcase
    // Vector travels with the fault pulse
    fvec_next = fault_next ? FAULT_VECTOR : 8'h00;
  end

  // State registers
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      state_reg <= ST_INIT;
      proto_reg <= 1'b0;
      sampled_reg <= 1'b0;
      fill_reg <= 3'h0;
      fvec_reg <= 8'h00;
      req_reg <= 1'b0;
      addr_reg <= 32'h00000000;
      wdata_reg <= 32'h00000000;
      kind_reg <= CYC_NONE;
      opc_reg <= 32'h00000000;
      stall_reg <= 1'b0;
      done_reg <= 1'b0;
      fault_reg <= 1'b0;
      brk_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      proto_reg <= proto_next;
      sampled_reg <= sampled_next;
      fill_reg <= fill_next;
      fvec_reg <= fvec_next;
      req_reg <= req_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      kind_reg <= kind_next;
      opc_reg <= opc_next;
      stall_reg <= stall_next;
      done_reg <= done_next;
      fault_reg <= fault_next;
      brk_reg <= brk_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // ports above programmed-I/O range
  // bit 2 of the address picks port
  assign o_io_req = req_reg;
  assign o_io_addr = addr_reg;
  assign o_io_wdata = wdata_reg;
  assign o_io_kind = kind_reg;
  assign o_stall = stall_reg;
  assign o_done = done_reg;
  assign o_fault = fault_reg;
  assign o_fault_vector = fvec_reg;
  assign o_irq_break = brk_reg;
  assign o_proto32 = proto_reg;
endmodule : numeric_coprocessor_port
`default_nettype wire

// >>> verification/copro_model.sv
`default_nettype none
// Far side coprocessor model
module copro_model (
  // Clock and bus
  input wire logic i_mclk,
  input wire logic i_io_req,
  input wire logic i_a2,
  // Scenario controls
  input wire logic [7:0] i_busy_len,
  input wire logic i_err,
  input wire logic i_opd,
  // Pins and ready
  output logic o_busy_n,
  output logic o_error_n,
  output logic o_opd_req,
  output logic o_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt;
  logic sel_n, pend;
  initial begin
    {o_busy_n, o_error_n, o_opd_req, o_ready, pend} = 5'h10;
    cnt = 0;
    repeat (14) @(posedge i_mclk);
    forever begin
      #1 o_error_n = !i_err;
      if (cnt > 0) cnt--;
      if (o_ready) begin
        o_ready = 0;
        if (!sel_n) {cnt, pend} = {32'(i_busy_len), i_opd};
        else o_opd_req = 0;
      end else if (i_io_req && $urandom_range(1, 0)) begin
        {o_ready, sel_n} = {1'b1, i_a2};
      end
      o_busy_n = (cnt == 0);
      if (cnt == 0 && pend) {o_opd_req, pend} = 2'h2;
      @(posedge i_mclk);
    end
  end
endmodule : copro_model
`default_nettype wire

// >>> verification/copro_port_monitor.sv
`default_nettype none
// ----------
// Port checker
// ----------
module copro_port_monitor
  import copro_port_pkg::*;
(
  // Watched ports
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic i_bus_ready,
  input wire logic o_io_req,
  input wire logic [31:0] o_io_addr,
  input wire logic [1:0] o_io_kind,
  input wire logic o_done,
  input wire logic o_fault,
  input wire logic [7:0] o_fault_vector,
  input wire logic o_irq_break
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  property p_opc;
    o_io_req && o_io_kind == CYC_OPCODE |-> o_io_addr == OPCODE_PORT_ADDR;
  endproperty
  a_opc: assert property (p_opc) else $error("opcode addr");
  property p_opd;
    o_io_req && o_io_kind == CYC_OPERAND |-> o_io_addr == OPERAND_PORT_ADDR;
  endproperty
  a_opd: assert property (p_opd) else $error("operand addr");
  property p_pio;
    o_io_req |-> o_io_addr > PIO_LIMIT;
  endproperty
  a_pio: assert property (p_pio) else $error("addr in pio");
  property p_sel;
    o_io_req |-> o_io_addr[SELECT_BIT] == (o_io_kind == CYC_OPERAND);
  endproperty
  a_sel: assert property (p_sel) else $error("select bit");
  property p_hold;
    o_io_req && !i_bus_ready |=> o_io_req && $stable(o_io_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("cycle dropped");
  property p_vec;
    o_fault_vector == (o_fault ? FAULT_VECTOR : 8'h00);
  endproperty
  a_vec: assert property (p_vec) else $error("fault vector");
  property p_one;
    o_done || o_fault |=> !o_done && !o_fault;
  endproperty
  a_one: assert property (p_one) else $error("long pulse");
  property p_excl;
    o_irq_break |-> !o_done && !o_fault;
  endproperty
  a_excl: assert property (p_excl) else $error("break clash");
  // Main scenarios
  c_done: cover property (o_done);
  c_flt: cover property (o_fault);
  c_brk: cover property (o_irq_break);
  c_opd: cover property (o_io_req && o_io_kind == CYC_OPERAND && i_bus_ready);
endmodule : copro_port_monitor
bind numeric_coprocessor_port copro_port_monitor u_copro_port_monitor (.*);
`default_nettype wire

// >>> verification/test_numeric_coprocessor_port.sv
`default_nettype none
module test_numeric_coprocessor_port;
  timeunit 1ns;
  timeprecision 100ps;
  import copro_port_pkg::*;
  logic i_mclk, i_sys_rst, i_busy_n, i_error_n, i_operand_transfer_request;
  logic i_esc_start, i_wait_start, i_nmi, i_maskable_irq, i_irq_enable;
  logic [31:0] i_esc_opcode, i_operand_data, o_io_addr, o_io_wdata;
  logic i_bus_ready, o_io_req, o_stall, o_done, o_fault, o_irq_break;
  logic o_proto32, err, opd;
  logic [1:0] o_io_kind;
  logic [7:0] o_fault_vector, busy_len;
  logic [2:0] evq[$];
  logic [63:0] ioq[$];
  int bad_count, total_checks, ev_cnt;
  numeric_coprocessor_port u_numeric_coprocessor_port (.*);
  copro_model u_copro_model (.i_mclk, .i_io_req(o_io_req),
    .i_a2(o_io_addr[SELECT_BIT]), .i_busy_len(busy_len), .i_err(err),
    .i_opd(opd), .o_busy_n(i_busy_n), .o_error_n(i_error_n),
    .o_opd_req(i_operand_transfer_request), .o_ready(i_bus_ready));
  initial begin
    i_mclk = 0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  task cmp_io(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp_io
  task cmp_ev(input logic [2:0] got, input logic [2:0] exp);
    cmp_io({61'h0, got}, {61'h0, exp});
  endtask : cmp_ev
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : summarize
  // Watcher takes oldest note per result
  always @(negedge i_mclk) begin
    if ({o_irq_break, o_fault, o_done} !== 3'h0) begin
      ev_cnt++;
      cmp_ev({o_irq_break, o_fault, o_done}, evq.pop_front());
    end
    if (o_io_req && i_bus_ready)
      if (o_io_kind === CYC_OPCODE)
        cmp_io({o_io_addr, o_io_wdata}, ioq.pop_front());
      else
        cmp_io({o_io_addr, o_io_wdata}, {OPERAND_PORT_ADDR, i_operand_data});
  end
  // One instruction: w wait, s interrupt kind
  task op(input logic w, input int s, input logic [2:0] ev);
    int n, k;
    @(posedge i_mclk);
    #1 evq.push_back(ev);
    k = ev_cnt;
    i_esc_opcode = $urandom;
    if (!w && ev == 3'h1) ioq.push_back({OPCODE_PORT_ADDR, i_esc_opcode});
    {i_wait_start, i_esc_start} = {w, !w};
    @(posedge i_mclk);
    #1 {i_wait_start, i_esc_start} = 2'h0;
    cmp_io({63'h0, o_stall}, 64'h1);
    repeat (6) @(posedge i_mclk);
    #1 {i_nmi, i_maskable_irq, i_irq_enable} = {s == 1, s > 1, s == 2};
    for (n = 0; n < 300 && ev_cnt == k; n++) @(posedge i_mclk);
    if (n == 300) begin
      bad_count++;
      summarize();
    end
    #1 {i_nmi, i_maskable_irq} = 2'h0;
    repeat (6) @(posedge i_mclk);
  endtask : op
  initial begin
    {i_sys_rst, i_esc_start, i_wait_start, i_nmi} = 4'h8;
    {i_maskable_irq, i_irq_enable, err, opd} = 4'h0;
    {i_esc_opcode, i_operand_data, busy_len} = {64'h0, 8'h03};
    {bad_count, total_checks, ev_cnt} = 0;
    void'($urandom(94));
    repeat (4) @(posedge i_mclk);
    #1 i_sys_rst = 0;
    i_operand_data = $urandom;
    repeat (16) @(posedge i_mclk);
    #1 cmp_io({63'h0, o_proto32}, 64'h1);
    op(0, 0, 3'h1);
    busy_len = 8'h1E;
    op(0, 0, 3'h1);
    op(1, 3, 3'h1);
    busy_len = 8'h3C;
    op(0, 0, 3'h1);
    op(1, 1, 3'h4);
    op(1, 2, 3'h4);
    op(1, 0, 3'h1);
    err = 1;
    repeat (8) @(posedge i_mclk);
    op(1, 0, 3'h2);
    op(0, 0, 3'h2);
    #1 {err, opd, busy_len} = {2'h1, 8'h04};
    repeat (8) @(posedge i_mclk);
    op(0, 0, 3'h1);
    repeat (40) @(posedge i_mclk);
    summarize();
  end
endmodule : test_numeric_coprocessor_port
`default_nettype wire
